// [src/memctl_pkg.sv]
package memctl_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PP_AW  = 7;

    // memory bus map
    localparam logic [15:0] SRAM_LAST  = 16'h7fff;
    localparam logic [15:0] PP_BASE    = 16'h8000;
    localparam logic [15:0] PP_LAST    = 16'h807f;
    localparam logic [15:0] EXT_BASE   = 16'h8080;
    localparam logic [15:0] EXT_LAST   = 16'h80ff;
    localparam logic [15:0] ROM_BASE   = 16'hc000;
    localparam logic [15:0] VEC_LAST   = 16'h0002;

    // reset vector jump
    localparam logic [7:0]  JUMP_OPCODE    = 8'h02;
    localparam logic [15:0] BOOT_ENTRY     = 16'hc000;
    localparam logic [15:0] UNPROG_TARGET  = 16'h0000;
    localparam logic [15:0] ROM_CHECK_ADDR = 16'hc000;
    localparam logic [7:0]  ROM_ERASED     = 8'hff;

    // processor port addresses
    localparam logic [6:0]  PP_BOOT_SEL_ADDR = 7'h7e;
    localparam logic [6:0]  CORE_NATIVE_LO   = 7'h00;
    localparam logic [6:0]  CORE_NATIVE_HI   = 7'h1f;

    // serial-port register indices and reset values
    localparam logic [6:0]  HOST_PROG_IDX     = 7'h01;
    localparam logic [6:0]  HOST_READBACK_IDX = 7'h02;
    localparam logic [6:0]  HOST_BOOT_SEL_IDX = 7'h03;
    localparam logic        PROG_RST          = 1'b0;
    localparam logic        READBACK_RST      = 1'b0;
    localparam logic        BOOT_SEL_RST      = 1'b1;

    typedef enum logic [2:0] {
        TGT_SRAM = 3'b000,
        TGT_ROM  = 3'b001,
        TGT_PP   = 3'b010,
        TGT_EXT  = 3'b011,
        TGT_VEC  = 3'b100,
        TGT_NONE = 3'b101
    } target_t;

    typedef enum logic {
        ST_CHECK = 1'b0,
        ST_RUN   = 1'b1
    } check_state_t;

    function automatic target_t decode(input logic [15:0] addr,
                                       input logic        boot_sel,
                                       input logic        is_read);
        if (boot_sel && is_read && addr <= VEC_LAST)
            return TGT_VEC;
        else if (addr <= SRAM_LAST)
            return TGT_SRAM;
        else if (addr >= PP_BASE && addr <= PP_LAST)
            return TGT_PP;
        else if (addr >= EXT_BASE && addr <= EXT_LAST)
            return TGT_EXT;
        else if (addr >= ROM_BASE)
            return TGT_ROM;
        else
            return TGT_NONE;
    endfunction

    function automatic logic is_core_native(input logic [6:0] a);
        return (a >= CORE_NATIVE_LO) && (a <= CORE_NATIVE_HI);
    endfunction

endpackage

// [src/vector_rom.sv]
`timescale 1ns/1ps
module vector_rom (
    input  wire logic [1:0] idx,         // low address bits of vector fetch
    input  wire logic       unprog,      // bootloader rom found erased
    output logic      [7:0] data         // jump instruction byte
);
    logic [15:0] target;

    always_comb begin
        target = unprog ? memctl_pkg::UNPROG_TARGET : memctl_pkg::BOOT_ENTRY;
        case (idx)
            2'h0:    data = memctl_pkg::JUMP_OPCODE;
            2'h1:    data = target[15:8];
            2'h2:    data = target[7:0];
            default: data = 8'h00;
        endcase
    end
endmodule // vector_rom

// [src/pp_port.sv]
`timescale 1ns/1ps
module pp_port (
    input  wire logic       ref_clk,     // core clock
    input  wire logic       nrst,        // async reset, active low
    input  wire logic [6:0] sfr_addr,    // direct register address
    input  wire logic       sfr_rd,      // direct read strobe
    input  wire logic       sfr_wr,      // direct write strobe
    input  wire logic [7:0] sfr_wdata,   // direct write data
    output logic      [7:0] sfr_rdata,   // direct read data, one cycle later
    input  wire logic [6:0] mem_addr,    // memory-side address
    input  wire logic       mem_rd,      // memory-side read request
    input  wire logic       mem_wr,      // memory-side write request
    input  wire logic [7:0] mem_wdata,   // memory-side write data
    output logic            mem_gnt,     // memory side may complete now
    output logic      [7:0] mem_rdata,   // memory-side read data
    output logic      [6:0] pp_addr,     // processor port bus address
    output logic            pp_rd,       // processor port read
    output logic            pp_wr,       // processor port write
    output logic      [7:0] pp_wdata,    // processor port write data
    input  wire logic [7:0] pp_rdata     // processor port read data
);
    logic sfr_act;
    logic mem_native;

    assign sfr_act    = sfr_rd | sfr_wr;
    assign mem_native = memctl_pkg::is_core_native(mem_addr);
    // direct access has priority; memory side just waits a cycle
    assign mem_gnt    = ~sfr_act;
    assign pp_addr    = sfr_act ? sfr_addr : mem_addr;
    assign pp_wdata   = sfr_act ? sfr_wdata : mem_wdata;
    // core-native registers never see a memory-side access
    assign pp_rd      = sfr_rd | (~sfr_act & mem_rd & ~mem_native);
    assign pp_wr      = sfr_wr | (~sfr_act & mem_wr & ~mem_native);
    assign mem_rdata  = mem_native ? 8'h00 : pp_rdata;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= pp_rdata;
        end
    end
endmodule // pp_port

// [src/mem_bus_ctrl.sv]
`timescale 1ns/1ps
// Function
// - processor port: single-cycle, 8-bit, 7-bit addresses
// - processor port reachable directly and via memory
// - core-native registers answer direct access only
// - bus serves cpu and serial host port
// - host may read rom and sram
// - program mode: cpu reset, host owns bus
// - readback mode: cpu ack low, host accesses
// - no mode: cpu signals pass through
// - boot select redirects reads of first three addresses
// - boot select clear: vector from sram
// - erased boot rom: vector points to zero
// - boot select shared by both register views
// - 0x8000-0x807f goes to processor port
// - 0x8080-0x80ff goes to extended registers
module mem_bus_ctrl (
    input  wire logic        ref_clk,         // 10 mhz core clock
    input  wire logic        nrst,            // async reset, active low
    // cpu external memory port
    input  wire logic [15:0] cpu_mem_addr,    // cpu address
    input  wire logic        cpu_mem_rd,      // cpu read request, held to ack
    input  wire logic        cpu_mem_wr,      // cpu write request, held to ack
    input  wire logic [7:0]  cpu_mem_wdata,   // cpu write data
    output logic      [7:0]  cpu_mem_rdata,   // cpu read data
    output logic             cpu_mem_ack,     // cpu access done, one cycle
    output logic             cpu_rst_hold,    // keeps the cpu in reset
    // cpu direct register port
    input  wire logic [6:0]  sfr_addr,        // direct register address
    input  wire logic        sfr_rd,          // direct read strobe
    input  wire logic        sfr_wr,          // direct write strobe
    input  wire logic [7:0]  sfr_wdata,       // direct write data
    output logic      [7:0]  sfr_rdata,       // direct read data
    // host through serial slave port: registers
    input  wire logic [6:0]  host_reg_addr,   // serial register index
    input  wire logic        host_reg_wr,     // serial register write
    input  wire logic [7:0]  host_reg_wdata,  // serial register data
    output logic      [7:0]  host_reg_rdata,  // serial register read data
    // host through serial slave port: memory bus
    input  wire logic [15:0] host_mem_addr,   // host address
    input  wire logic        host_mem_rd,     // host read request, held to ack
    input  wire logic        host_mem_wr,     // host write request, held to ack
    input  wire logic [7:0]  host_mem_wdata,  // host write data
    output logic      [7:0]  host_mem_rdata,  // host read data
    output logic             host_mem_ack,    // host access done, one cycle
    output logic             host_owns_bus,   // host mode active
    // rom
    output logic      [15:0] rom_addr,        // rom address
    output logic             rom_rd,          // rom read strobe
    input  wire logic [7:0]  rom_rdata,       // rom data, same cycle
    // sram
    output logic      [15:0] sram_addr,       // sram address
    output logic             sram_rd,         // sram read strobe
    output logic             sram_wr,         // sram write strobe
    output logic      [7:0]  sram_wdata,      // sram write data
    input  wire logic [7:0]  sram_rdata,      // sram data, same cycle
    // processor port register bus
    output logic      [6:0]  pp_addr,         // register address
    output logic             pp_rd,           // register read strobe
    output logic             pp_wr,           // register write strobe
    output logic      [7:0]  pp_wdata,        // register write data
    input  wire logic [7:0]  pp_rdata,        // register data, same cycle
    // extended register space
    output logic      [6:0]  ext_addr,        // register address
    output logic             ext_rd,          // register read strobe
    output logic             ext_wr,          // register write strobe
    output logic      [7:0]  ext_wdata,       // register write data
    input  wire logic [7:0]  ext_rdata        // register data, same cycle
);
    memctl_pkg::check_state_t state_r;
    memctl_pkg::target_t      tgt;

    logic        prog_r;
    logic        readback_r;
    logic        boot_sel_r;
    logic        unprog_r;
    logic        owner_host;
    logic        checking;
    logic [15:0] m_addr;
    logic        m_rd;
    logic        m_wr;
    logic [7:0]  m_wdata;
    logic        m_ack_r;
    logic        m_req;
    logic        pp_gnt;
    logic        accept;
    logic [7:0]  vec_data;
    logic [7:0]  pp_mem_rdata;
    logic [7:0]  pp_rdata_mux;
    logic        pp_mem_rd;
    logic        pp_mem_wr;
    logic        boot_pp_wr;
    logic        boot_host_wr;
    logic [7:0]  rdata_nxt;
    logic [7:0]  rdata_r;
    logic        cpu_ack_r;
    logic        host_ack_r;
    logic [7:0]  host_reg_rdata_r;

    assign checking      = (state_r == memctl_pkg::ST_CHECK);
    // program mode takes precedence, readback alone only stalls
    assign owner_host    = prog_r | readback_r;
    assign host_owns_bus = owner_host;
    assign cpu_rst_hold  = prog_r | checking;

    // bus source select
    always_comb begin
        if (owner_host) begin
            m_addr  = host_mem_addr;
            m_rd    = host_mem_rd;
            m_wr    = host_mem_wr;
            m_wdata = host_mem_wdata;
            m_ack_r = host_ack_r;
        end else begin
            m_addr  = cpu_mem_addr;
            m_rd    = cpu_mem_rd;
            m_wr    = cpu_mem_wr;
            m_wdata = cpu_mem_wdata;
            m_ack_r = cpu_ack_r;
        end
    end

    // a held request is not taken again in its own ack cycle
    assign m_req = (m_rd | m_wr) & ~m_ack_r & ~checking;
    assign tgt   = memctl_pkg::decode(m_addr, boot_sel_r, m_rd);
    assign accept = m_req & ((tgt != memctl_pkg::TGT_PP) | pp_gnt);

    // rom: power-on check read, otherwise bus reads
    always_comb begin
        if (checking) begin
            rom_addr = memctl_pkg::ROM_CHECK_ADDR;
            rom_rd   = 1'b1;
        end else begin
            rom_addr = m_addr;
            rom_rd   = accept & m_rd & (tgt == memctl_pkg::TGT_ROM);
        end
    end

    assign sram_addr  = m_addr;
    assign sram_wdata = m_wdata;
    // vector fetch with boot select clear falls through to sram
    assign sram_rd    = accept & m_rd & (tgt == memctl_pkg::TGT_SRAM);
    assign sram_wr    = accept & m_wr & (tgt == memctl_pkg::TGT_SRAM);

    assign ext_addr   = m_addr[6:0];
    assign ext_wdata  = m_wdata;
    assign ext_rd     = accept & m_rd & (tgt == memctl_pkg::TGT_EXT);
    assign ext_wr     = accept & m_wr & (tgt == memctl_pkg::TGT_EXT);

    assign pp_mem_rd  = m_req & m_rd & (tgt == memctl_pkg::TGT_PP);
    assign pp_mem_wr  = m_req & m_wr & (tgt == memctl_pkg::TGT_PP);

    // boot select lives on the processor port as well
    assign pp_rdata_mux = (pp_addr == memctl_pkg::PP_BOOT_SEL_ADDR) ?
                          {7'h00, boot_sel_r} : pp_rdata;
    assign boot_pp_wr   = pp_wr & (pp_addr == memctl_pkg::PP_BOOT_SEL_ADDR);
    assign boot_host_wr = host_reg_wr & (host_reg_addr == memctl_pkg::HOST_BOOT_SEL_IDX);

    pp_port u_pp_port (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .sfr_addr  (sfr_addr),
        .sfr_rd    (sfr_rd),
        .sfr_wr    (sfr_wr),
        .sfr_wdata (sfr_wdata),
        .sfr_rdata (sfr_rdata),
        .mem_addr  (m_addr[6:0]),
        .mem_rd    (pp_mem_rd),
        .mem_wr    (pp_mem_wr),
        .mem_wdata (m_wdata),
        .mem_gnt   (pp_gnt),
        .mem_rdata (pp_mem_rdata),
        .pp_addr   (pp_addr),
        .pp_rd     (pp_rd),
        .pp_wr     (pp_wr),
        .pp_wdata  (pp_wdata),
        .pp_rdata  (pp_rdata_mux)
    );

    vector_rom u_vector_rom (
        .idx    (m_addr[1:0]),
        .unprog (unprog_r),
        .data   (vec_data)
    );

    always_comb begin
        case (tgt)
            memctl_pkg::TGT_SRAM: rdata_nxt = sram_rdata;
            memctl_pkg::TGT_ROM:  rdata_nxt = rom_rdata;
            memctl_pkg::TGT_PP:   rdata_nxt = pp_mem_rdata;
            memctl_pkg::TGT_EXT:  rdata_nxt = ext_rdata;
            memctl_pkg::TGT_VEC:  rdata_nxt = vec_data;
            default:              rdata_nxt = 8'h00;
        endcase
    end

    // power-on check of the bootloader rom, one read
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r  <= memctl_pkg::ST_CHECK;
            unprog_r <= 1'b0;
        end else begin
            case (state_r)
                memctl_pkg::ST_CHECK: begin
                    unprog_r <= (rom_rdata == memctl_pkg::ROM_ERASED);
                    state_r  <= memctl_pkg::ST_RUN;
                end
                memctl_pkg::ST_RUN: begin
                    state_r  <= memctl_pkg::ST_RUN;
                end
                default: begin
                    state_r  <= memctl_pkg::ST_CHECK;
                end
            endcase
        end
    end

    // access completion; cpu sees no ack while the host owns the bus
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cpu_ack_r  <= 1'b0;
            host_ack_r <= 1'b0;
            rdata_r    <= 8'h00;
        end else begin
            cpu_ack_r  <= accept & ~owner_host;
            host_ack_r <= accept & owner_host;
            if (accept && m_rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // a mode set in the ack cycle still stalls; the cpu retries that access
    assign cpu_mem_ack    = cpu_ack_r & ~owner_host;
    assign host_mem_ack   = host_ack_r;
    assign cpu_mem_rdata  = rdata_r;
    assign host_mem_rdata = rdata_r;

    // mode bits written by the host over the serial port
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prog_r     <= memctl_pkg::PROG_RST;
            readback_r <= memctl_pkg::READBACK_RST;
        end else if (host_reg_wr) begin
            if (host_reg_addr == memctl_pkg::HOST_PROG_IDX) begin
                prog_r <= host_reg_wdata[0];
            end
            if (host_reg_addr == memctl_pkg::HOST_READBACK_IDX) begin
                readback_r <= host_reg_wdata[0];
            end
        end
    end

    // host write wins a same-cycle collision with the processor port
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            boot_sel_r <= memctl_pkg::BOOT_SEL_RST;
        end else if (boot_host_wr) begin
            boot_sel_r <= host_reg_wdata[0];
        end else if (boot_pp_wr) begin
            boot_sel_r <= pp_wdata[0];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            host_reg_rdata_r <= 8'h00;
        end else begin
            case (host_reg_addr)
                memctl_pkg::HOST_PROG_IDX:     host_reg_rdata_r <= {7'h00, prog_r};
                memctl_pkg::HOST_READBACK_IDX: host_reg_rdata_r <= {7'h00, readback_r};
                memctl_pkg::HOST_BOOT_SEL_IDX: host_reg_rdata_r <= {7'h00, boot_sel_r};
                default:                       host_reg_rdata_r <= 8'h00;
            endcase
        end
    end

    assign host_reg_rdata = host_reg_rdata_r;
endmodule // mem_bus_ctrl

// [tb/mem_bus_props.sv]
`timescale 1ns/1ps
module mem_bus_props (
    input wire logic        ref_clk,        // core clock
    input wire logic        nrst,           // async reset, active low
    input wire logic [15:0] cpu_mem_addr,   // cpu address
    input wire logic        cpu_mem_rd,     // cpu read
    input wire logic        cpu_mem_ack,    // cpu ack
    input wire logic        cpu_rst_hold,   // cpu reset
    input wire logic [6:0]  sfr_addr,       // direct address
    input wire logic        sfr_rd,         // direct read
    input wire logic        sfr_wr,         // direct write
    input wire logic [6:0]  host_reg_addr,  // serial index
    input wire logic        host_reg_wr,    // serial write
    input wire logic [7:0]  host_reg_wdata, // serial data
    input wire logic [15:0] host_mem_addr,  // host address
    input wire logic        host_owns_bus,  // host mode
    input wire logic [15:0] sram_addr,      // sram address
    input wire logic        sram_rd,        // sram read
    input wire logic        sram_wr,        // sram write
    input wire logic [6:0]  pp_addr,        // register address
    input wire logic        pp_rd,          // register read
    input wire logic        pp_wr,          // register write
    input wire logic [6:0]  ext_addr,       // ext address
    input wire logic        ext_rd          // ext read
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_sfr_wr; sfr_wr |-> pp_wr && pp_addr == sfr_addr; endproperty
    a_sfr_wr: assert property (p_sfr_wr) else $error("direct write not on bus");
    property p_sfr_rd; sfr_rd |-> pp_rd && pp_addr == sfr_addr; endproperty
    a_sfr_rd: assert property (p_sfr_rd) else $error("direct read not on bus");
    property p_native; pp_rd && !sfr_rd |-> pp_addr > memctl_pkg::CORE_NATIVE_HI; endproperty
    a_native: assert property (p_native) else $error("core register via memory");
    property p_pp_win;
        pp_wr && !sfr_wr && !host_owns_bus
            |-> cpu_mem_addr[15:7] == 9'h100 && pp_addr == cpu_mem_addr[6:0];
    endproperty
    a_pp_win: assert property (p_pp_win) else $error("register window wrong");
    property p_ext;
        ext_rd && !host_owns_bus |-> cpu_mem_addr[15:7] == 9'h101 && ext_addr == cpu_mem_addr[6:0];
    endproperty
    a_ext: assert property (p_ext) else $error("ext window wrong");
    property p_pass; sram_rd && !host_owns_bus |-> cpu_mem_rd && sram_addr == cpu_mem_addr;
    endproperty
    a_pass: assert property (p_pass) else $error("cpu read not passed");
    property p_host; (sram_rd || sram_wr) && host_owns_bus |-> sram_addr == host_mem_addr;
    endproperty
    a_host: assert property (p_host) else $error("host access not passed");
    property p_stall; host_owns_bus |-> !cpu_mem_ack; endproperty
    a_stall: assert property (p_stall) else $error("cpu acked in host mode");
    property p_ack; sram_rd && !host_owns_bus && !host_reg_wr |=> cpu_mem_ack; endproperty
    a_ack: assert property (p_ack) else $error("cpu ack late");
    property p_prog;
        host_reg_wr && host_reg_addr == memctl_pkg::HOST_PROG_IDX && host_reg_wdata[0]
            |=> cpu_rst_hold && host_owns_bus;
    endproperty
    a_prog: assert property (p_prog) else $error("program mode not held");
    property p_free;
        host_reg_wr && host_reg_addr == memctl_pkg::HOST_PROG_IDX && !host_reg_wdata[0]
            |=> !cpu_rst_hold;
    endproperty
    a_free: assert property (p_free) else $error("cpu not released");
endmodule // mem_bus_props
bind mem_bus_ctrl mem_bus_props u_props (.*);

// [tb/mem_far_model.sv]
`timescale 1ns/1ps
module mem_far_model (
    input  wire logic        ref_clk,     // core clock
    input  wire logic        rom_erased,  // rom reads blank
    input  wire logic [15:0] rom_addr,    // rom address
    input  wire logic        rom_rd,      // rom strobe
    output logic      [7:0]  rom_rdata,   // rom data
    input  wire logic [15:0] sram_addr,   // sram address
    input  wire logic        sram_rd,     // sram read
    input  wire logic        sram_wr,     // sram write
    input  wire logic [7:0]  sram_wdata,  // sram data in
    output logic      [7:0]  sram_rdata,  // sram data out
    input  wire logic [6:0]  pp_addr,     // register address
    input  wire logic        pp_rd,       // register read
    input  wire logic        pp_wr,       // register write
    input  wire logic [7:0]  pp_wdata,    // register data in
    output logic      [7:0]  pp_rdata,    // register data out
    input  wire logic [6:0]  ext_addr,    // ext address
    input  wire logic        ext_rd,      // ext read
    input  wire logic        ext_wr,      // ext write
    input  wire logic [7:0]  ext_wdata,   // ext data in
    output logic      [7:0]  ext_rdata    // ext data out
);
    logic [7:0] sram_q [256];
    logic [7:0] pp_q [128];
    logic [7:0] ext_q [128];
    always_ff @(posedge ref_clk) begin
        if (sram_wr) sram_q[sram_addr[7:0]] <= sram_wdata;
        if (pp_wr) pp_q[pp_addr] <= pp_wdata;
        if (ext_wr) ext_q[ext_addr] <= ext_wdata;
    end
    // unselected reads show a moving pattern so stale data cannot pass
    assign rom_rdata = !rom_rd ? ~rom_addr[7:0] :
                       rom_erased ? 8'hff : rom_addr[15:8] ^ rom_addr[7:0];
    assign sram_rdata = sram_rd ? sram_q[sram_addr[7:0]] : ~sram_addr[7:0];
    assign pp_rdata = pp_rd ? pp_q[pp_addr] : {1'b1, ~pp_addr};
    assign ext_rdata = ext_rd ? ext_q[ext_addr] : {1'b0, ~ext_addr};
endmodule // mem_far_model

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
    logic ref_clk = 0, nrst = 0, rom_erased = 0;
    logic [15:0] cpu_mem_addr = 0, host_mem_addr = 0, rom_addr, sram_addr;
    logic cpu_mem_rd = 0, cpu_mem_wr = 0, sfr_rd = 0, sfr_wr = 0, host_reg_wr = 0;
    logic host_mem_rd = 0, host_mem_wr = 0, cpu_mem_ack, cpu_rst_hold, host_mem_ack;
    logic [7:0] cpu_mem_wdata = 0, sfr_wdata = 0, host_reg_wdata = 0, host_mem_wdata = 0;
    logic [6:0] sfr_addr = 0, host_reg_addr = 0, pp_addr, ext_addr;
    logic [7:0] cpu_mem_rdata, sfr_rdata, host_reg_rdata, host_mem_rdata, rom_rdata;
    logic [7:0] sram_wdata, sram_rdata, pp_wdata, pp_rdata, ext_wdata, ext_rdata, q, q2;
    logic host_owns_bus, rom_rd, sram_rd, sram_wr, pp_rd, pp_wr, ext_rd, ext_wr;
    logic [15:0] a;
    logic [7:0] mirror [256];
    int fails = 0, comparisons = 0, cpu_acks = 0, n0;

    mem_bus_ctrl DUT (.*);
    mem_far_model u_far (.*);

    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (cpu_mem_ack === 1'b1) cpu_acks++;

    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] vec(input int i, input logic erased);
        logic [15:0] t;
        t = erased ? memctl_pkg::UNPROG_TARGET : memctl_pkg::BOOT_ENTRY;
        return i == 0 ? memctl_pkg::JUMP_OPCODE : i == 1 ? t[15:8] : t[7:0];
    endfunction
    task automatic mem_op(input bit host, input logic wr, input logic [15:0] ad,
                          input logic [7:0] d, output logic [7:0] r);
        int n;
        @(posedge ref_clk);
        #1;
        if (host) {host_mem_addr, host_mem_wdata, host_mem_wr, host_mem_rd} = {ad, d, wr, !wr};
        else {cpu_mem_addr, cpu_mem_wdata, cpu_mem_wr, cpu_mem_rd} = {ad, d, wr, !wr};
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (((host ? host_mem_ack : cpu_mem_ack) !== 1'b1) && n < 200);
        if (n >= 200) fails++;
        r = host ? host_mem_rdata : cpu_mem_rdata;
        if (host) {host_mem_addr, host_mem_wr, host_mem_rd} = {~ad, 2'b00};
        else {cpu_mem_addr, cpu_mem_wr, cpu_mem_rd} = {~ad, 2'b00};
    endtask
    task automatic sfr_op(input logic wr, input logic [6:0] ad, input logic [7:0] d,
                          output logic [7:0] r);
        @(posedge ref_clk);
        #1;
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {ad, d, wr, !wr};
        @(posedge ref_clk);
        #1;
        {sfr_wr, sfr_rd} = 2'b00;
        r = sfr_rdata;
    endtask
    task automatic hreg(input logic wr, input logic [6:0] idx, input logic [7:0] d,
                        output logic [7:0] r);
        @(posedge ref_clk);
        #1;
        {host_reg_addr, host_reg_wdata, host_reg_wr} = {idx, d, wr};
        @(posedge ref_clk);
        #1;
        host_reg_wr = 0;
        r = host_reg_rdata;
    endtask
    task automatic do_reset(input logic erased);
        nrst = 0;
        rom_erased = erased;
        repeat (12) @(posedge ref_clk);
        #1;
        nrst = 1;
    endtask

    initial begin
        #(100 * 6000);
        fails++;
        print_verdict();
    end

    initial begin
        n0 = $urandom(32'h9f7d440b);
        do_reset(0);
        for (int i = 0; i < 3; i++) begin
            mem_op(0, 0, 16'(i), 8'h00, q);
            chk8(q, vec(i, 0));
        end
        mem_op(0, 1, 16'h0001, 8'h77, q);
        mem_op(0, 1, 16'h0033, 8'hc3, q);
        mirror[8'h33] = 8'hc3;
        for (int i = 0; i < 16; i++) begin
            a = {1'b0, 7'($urandom), 8'($urandom) | 8'h40};
            mirror[a[7:0]] = 8'($urandom);
            mem_op(0, 1, a, mirror[a[7:0]], q);
            mem_op(0, 0, a, 8'h00, q);
            chk8(q, mirror[a[7:0]]);
            a = 16'hc000 | 16'($urandom);
            mem_op(0, 0, a, 8'h00, q);
            chk8(q, a[15:8] ^ a[7:0]);
        end
        mem_op(0, 1, 16'h8040, 8'h3c, q);
        sfr_op(0, 7'h40, 8'h00, q);
        chk8(q, 8'h3c);
        sfr_op(1, 7'h41, 8'ha5, q);
        mem_op(0, 0, 16'h8041, 8'h00, q);
        chk8(q, 8'ha5);
        sfr_op(1, 7'h05, 8'h66, q);
        mem_op(0, 0, 16'h8005, 8'h00, q);
        chk8(q, 8'h00);
        mem_op(0, 1, 16'h80ff, 8'h99, q);
        mem_op(0, 0, 16'h80ff, 8'h00, q);
        chk8(q, 8'h99);
        mem_op(0, 0, 16'h9000, 8'h00, q);
        chk8(q, 8'h00);
        hreg(0, 7'h03, 8'h00, q);
        chk1(q[0], 1'b1);
        sfr_op(1, 7'h7e, 8'h00, q);
        hreg(0, 7'h03, 8'h00, q);
        chk1(q[0], 1'b0);
        mem_op(0, 0, 16'h0001, 8'h00, q);
        chk8(q, 8'h77);
        hreg(1, 7'h03, 8'h01, q);
        sfr_op(0, 7'h7e, 8'h00, q);
        chk1(q[0], 1'b1);
        hreg(1, 7'h03, 8'h00, q);
        hreg(1, 7'h02, 8'h01, q);
        n0 = cpu_acks;
        fork
            mem_op(0, 0, 16'h0033, 8'h00, q);
            begin
                mem_op(1, 0, 16'h0033, 8'h00, q2);
                chk8(q2, 8'hc3);
                chk1(cpu_acks == n0, 1'b1);
                hreg(1, 7'h02, 8'h00, q2);
            end
        join
        chk8(q, 8'hc3);
        hreg(1, 7'h01, 8'h01, q);
        chk1(cpu_rst_hold, 1'b1);
        mem_op(1, 1, 16'h0020, 8'h5e, q);
        mem_op(1, 0, 16'hc123, 8'h00, q);
        chk8(q, 8'he2);
        hreg(1, 7'h02, 8'h01, q);
        chk1(cpu_rst_hold, 1'b1);
        hreg(1, 7'h01, 8'h00, q);
        chk1(cpu_rst_hold, 1'b0);
        chk1(host_owns_bus, 1'b1);
        hreg(1, 7'h02, 8'h00, q);
        chk1(host_owns_bus, 1'b0);
        mem_op(0, 0, 16'h0020, 8'h00, q);
        chk8(q, 8'h5e);
        do_reset(1);
        for (int i = 0; i < 3; i++) begin
            mem_op(0, 0, 16'(i), 8'h00, q);
            chk8(q, vec(i, 1));
        end
        print_verdict();
    end
endmodule // tb
